// >>> verilog/reg_framer.v
// registration frame builder, acknowledgement parser and grant gate
`timescale 1ns/10ps
`include "reg_framer_defines.vh"
module reg_framer #(
   parameter GAP_TQ = 11'h400 // least spacing between grants, quanta
) (
   // clock and reset
   input wire clk_sys,
   input wire rstn,
   // registration request from the scheduler
   input wire regStart,
   input wire [47:0] regDestAddr,
   input wire [15:0] regPort,
   input wire [7:0] regFlags,
   input wire [15:0] rxSyncPmd,
   input wire [15:0] rxSyncPma,
   input wire [15:0] rxSyncPcs,
   input wire [7:0] regPendGrants,
   output wire regBusy,
   output reg regRefused_reg,
   // transmit octet stream
   output reg txValid_reg,
   output reg [7:0] txData_reg,
   output reg txLast_reg,
   output reg [15:0] txLlid_reg,
   output reg [47:0] txDestAddr_reg,
   input wire txReady,
   // receive octet stream of acknowledgement frames
   input wire rxValid,
   input wire [7:0] rxData,
   input wire rxLast,
   // parsed acknowledgement
   output reg ackSeen_reg,
   output reg ackOk_reg,
   output reg [15:0] ackPort_reg,
   output reg [15:0] ackSync_reg,
   output reg ackMatch_reg,
   // link deallocation
   output reg deregPulse_reg,
   output reg [15:0] deregPort_reg,
   // grant gate
   input wire grantReq,
   input wire [31:0] grantStart,
   input wire [31:0] localTime,
   input wire [7:0] grantsOutstanding,
   output wire grantOk,
   output reg quantumTick_reg
);
   // overview
   // - a registration request is taken when idle and not aimed at a group
   // - the frame leaves as a fixed-length octet stream, one octet per beat
   // - the stream holds each octet until the far side is ready
   // - all fields are latched at the request, so inputs may move after it
   // - the echoed acknowledgement is parsed octet by octet as it arrives
   // - the parser keeps no frame buffer; fields are captured in place
   // - a reserved ack flag or wrong opcode is dropped without a report
   // - the grant gate is purely combinational and costs no latency
   // - a granted cycle counts as issued, so the caller must not retry it
   // limitations
   // - only one frame is in flight; a request while busy is lost
   // - the sync sum saturates rather than wraps, trading accuracy for safety
   // - the quantum is approximated by four clock cycles
   // - the pending limit is the one of the latest frame, not per unit
   // - the lead check treats a start more than half the clock range ahead
   //   as lying in the past, which is the safer reading
   // timing
   // - first octet two cycles after the request edge
   // - acknowledgement report one cycle after its last octet
   // reset
   // - synchronous, active low; outputs clear on the first edge
   // - first request may come on the edge after release
   // frame layout, octet by octet
   // - 0..1 opcode, high octet first
   // - 2..3 assigned port
   // - 4 flags
   // - 5..6 sync time
   // - 7 echoed pending grants
   // - 8 onward zero pad up to the fixed length
   // - the ack uses the same positions up to its sync time
   // grant gate
   // - lead time from the local clock must reach the minimum
   // - spacing is counted in quanta from the previous granted cycle
   // - outstanding grants must stay below the echoed pending count
   // - before the first frame the pending count is zero, so nothing passes

   // transmit states, one-hot
   localparam TX_IDLE = 2'b01;
   localparam TX_SEND = 2'b10;
   reg [1:0] txState_reg; // transmit state
   reg [5:0] txIdx_reg; // octet index in payload
   // latched frame fields
   reg [15:0] port_reg; // latched assigned port
   reg [7:0] flags_reg; // latched flags
   reg [15:0] sync_reg; // latched advertised sync time
   reg [7:0] pend_reg; // latched pending grants
   reg [7:0] txByte; // octet at current index
   reg [17:0] syncSum; // sum of sublayer sync needs
   // echo reference kept from the last frame sent
   reg [15:0] lastSync_reg; // last advertised sync time
   reg [15:0] lastPort_reg; // last assigned port
   reg [1:0] qDiv_reg; // quantum divider
   reg [10:0] gapCnt_reg; // quanta since last grant
   // parser state
   reg [5:0] rxIdx_reg; // receive octet index
   reg [15:0] rxOpc_reg; // received opcode
   reg [7:0] rxFlags_reg; // received flags
   reg [15:0] rxPort_reg; // received port
   reg [15:0] rxSync_reg; // received sync
   // grant gate and helpers
   wire groupDa; // destination is a group address
   wire leadOk; // grant start far enough ahead
   wire [31:0] leadTime; // start minus now
   wire [15:0] opcReg; // registration opcode as a vector
   wire [15:0] rxSyncNow; // sync field including the octet on the bus
   wire gapOk; // spacing since last grant met
   wire pendOk; // fewer grants out than the unit buffers

   // a refused request never reaches the wire
   assign groupDa = regDestAddr[`DA_GROUP_BIT];
   assign regBusy = (txState_reg != TX_IDLE);
   // opcode held in a vector so each octet is a plain slice
   assign opcReg = `OPC_REGISTER;
   // a seven-octet ack ends on the sync low octet, not yet in its register
   assign rxSyncNow = (rxIdx_reg == `POS_ACK_SYNC_LO) ?
                      {rxSync_reg[15:8], rxData} : rxSync_reg;

   // sublayer needs summed, saturated to field width
   // two spare bits keep the carry of three addends
   always @* begin
      syncSum = {2'b00, rxSyncPmd} + {2'b00, rxSyncPma} + {2'b00, rxSyncPcs};
   end

   // octet mux in field order, high octet first; rest is zero pad
   always @* begin
      case (txIdx_reg)
         `POS_OPC_HI: txByte = opcReg[15:8];
         `POS_OPC_LO: txByte = opcReg[7:0];
         `POS_PORT_HI: txByte = port_reg[15:8];
         `POS_PORT_LO: txByte = port_reg[7:0];
         `POS_FLAGS: txByte = flags_reg;
         `POS_SYNC_HI: txByte = sync_reg[15:8];
         `POS_SYNC_LO: txByte = sync_reg[7:0];
         `POS_PEND: txByte = pend_reg;
         // any index past the pending octet is pad
         default: txByte = 8'h00;
      endcase
   end

   // transmit machine; one octet per accepted beat
   always @(posedge clk_sys) begin
      if (!rstn) begin
         // idle, nothing latched
         txState_reg <= TX_IDLE;
         txIdx_reg <= 6'h00;
         port_reg <= 16'h0000;
         flags_reg <= 8'h00;
         sync_reg <= 16'h0000;
         pend_reg <= 8'h00;
         txValid_reg <= 1'b0;
         txData_reg <= 8'h00;
         txLast_reg <= 1'b0;
         txLlid_reg <= 16'h0000;
         txDestAddr_reg <= 48'h0;
         regRefused_reg <= 1'b0;
         lastSync_reg <= 16'h0000;
         lastPort_reg <= 16'h0000;
         deregPulse_reg <= 1'b0;
         deregPort_reg <= 16'h0000;
      end else begin
         // one-cycle pulses drop back by default
         regRefused_reg <= 1'b0;
         deregPulse_reg <= 1'b0;
         case (txState_reg)
            TX_IDLE: begin
               // a group address is never framed; the caller sees a refusal
               if (regStart && groupDa) begin
                  regRefused_reg <= 1'b1;
               end else if (regStart) begin
                  // latch every field so the caller may change its inputs
                  port_reg <= regPort;
                  flags_reg <= regFlags;
                  // saturate rather than wrap: a short sync time loses bursts
                  sync_reg <= (syncSum[17:16] != 2'b00) ? 16'hffff : syncSum[15:0];
                  pend_reg <= regPendGrants;
                  txDestAddr_reg <= regDestAddr;
                  txLlid_reg <= `LLID_BCAST;
                  txIdx_reg <= 6'h00;
                  txState_reg <= TX_SEND;
               end
            end
            TX_SEND: begin
               if (!txValid_reg || txReady) begin
                  // load next octet once the previous one is taken
                  if (txValid_reg && txLast_reg) begin
                     txValid_reg <= 1'b0;
                     txLast_reg <= 1'b0;
                     txState_reg <= TX_IDLE;
                     lastSync_reg <= sync_reg;
                     lastPort_reg <= port_reg;
                     // the port is freed only once the frame is fully out
                     if (flags_reg == `FLG_DEREG) begin
                        deregPulse_reg <= 1'b1;
                        deregPort_reg <= port_reg;
                     end
                  end else begin
                     // next octet; the last is flagged so the sink closes the frame
                     txValid_reg <= 1'b1;
                     txData_reg <= txByte;
                     txLast_reg <= (txIdx_reg == `PAYLOAD_LEN - 6'h01);
                     txIdx_reg <= txIdx_reg + 6'h01;
                  end
               end
               // a stalled beat keeps octet, last flag and index untouched
            end
            // an illegal state recovers to idle
            default: txState_reg <= TX_IDLE;
         endcase
      end
   end

   // acknowledgement parser; pad octets beyond sync are disregarded
   always @(posedge clk_sys) begin
      if (!rstn) begin
         // fields cleared so a stale echo cannot match
         rxIdx_reg <= 6'h00;
         rxOpc_reg <= 16'h0000;
         rxFlags_reg <= 8'h00;
         rxPort_reg <= 16'h0000;
         rxSync_reg <= 16'h0000;
         ackSeen_reg <= 1'b0;
         ackOk_reg <= 1'b0;
         ackPort_reg <= 16'h0000;
         ackSync_reg <= 16'h0000;
         ackMatch_reg <= 1'b0;
      end else begin
         // report pulse lasts one cycle
         ackSeen_reg <= 1'b0;
         if (rxValid) begin
            // index stops at the top so long frames cannot wrap into the fields
            if (rxLast) begin
               rxIdx_reg <= 6'h00;
            end else if (rxIdx_reg != 6'h3f) begin
               rxIdx_reg <= rxIdx_reg + 6'h01;
            end
            case (rxIdx_reg)
               `POS_OPC_HI: rxOpc_reg[15:8] <= rxData;
               `POS_OPC_LO: rxOpc_reg[7:0] <= rxData;
               `POS_PORT_HI: rxPort_reg[15:8] <= rxData;
               `POS_PORT_LO: rxPort_reg[7:0] <= rxData;
               `POS_FLAGS: rxFlags_reg <= rxData;
               `POS_ACK_SYNC_HI: rxSync_reg[15:8] <= rxData;
               `POS_ACK_SYNC_LO: rxSync_reg[7:0] <= rxData;
               default: ;
            endcase
            // a short frame or a reserved flag value is dropped silently
            // report only on the last octet; earlier octets only fill fields
            if (rxLast && rxIdx_reg >= `POS_ACK_SYNC_LO && rxOpc_reg == `OPC_REG_ACK &&
                (rxFlags_reg == `AFLG_ACK || rxFlags_reg == `AFLG_NACK)) begin
               ackSeen_reg <= 1'b1;
               ackOk_reg <= (rxFlags_reg == `AFLG_ACK);
               ackPort_reg <= rxPort_reg;
               ackSync_reg <= rxSyncNow;
               ackMatch_reg <= (rxPort_reg == lastPort_reg) &&
                               (rxSyncNow == lastSync_reg);
            end
         end
      end
   end

   // quantum tick: 16 ns approximated by four 5 ns cycles, which is 20 ns
   always @(posedge clk_sys) begin
      if (!rstn) begin
         qDiv_reg <= 2'b00;
         quantumTick_reg <= 1'b0;
      end else begin
         // the divider free-runs; nothing here waits on traffic
         qDiv_reg <= qDiv_reg + 2'b01;
         quantumTick_reg <= (qDiv_reg == `QUANTUM_CYC - 1);
      end
   end

   // grant gate: lead time, spacing and pending limit
   // leadTime wraps when the start lies behind; bit 31 catches that
   assign leadTime = grantStart - localTime;
   assign leadOk = (leadTime >= `GRANT_LEAD_TQ) && !leadTime[31];
   // spacing since the last granted cycle
   assign gapOk = (gapCnt_reg >= GAP_TQ);
   // never more grants ahead than the unit can buffer
   assign pendOk = (grantsOutstanding < pend_reg);
   assign grantOk = grantReq && leadOk && gapOk && pendOk;

   // spacing counter saturates; restarts on each granted message
   always @(posedge clk_sys) begin
      if (!rstn) begin
         // start open so the first grant is not delayed
         gapCnt_reg <= GAP_TQ;
      end else if (grantOk) begin
         gapCnt_reg <= 11'h000;
      end else if (quantumTick_reg && gapCnt_reg < GAP_TQ) begin
         gapCnt_reg <= gapCnt_reg + 11'h001;
      end
   end
endmodule

// >>> verilog/reg_framer_defines.vh
// constants for the registration frame builder and acknowledgement parser
// Behaviour
// - registration frame goes to unicast destination only
// - registration opcode is 00-05
// - sixteen-bit assigned port field carried
// - register flags 1..4 meaningful, others ignored
// - deregister flag frees port and link id
// - sync time covers all receiver sublayer needs
// - grants ahead limited to echoed pending count
// - pad sent as zeros, ignored on receive
// - registration frame tagged with broadcast link id
// - ack flags 0 nack, 1 ack, others ignored
// - mac and phy delay varies one quantum
// - grant start at least 1024 quanta ahead
// - at most one grant per 1024 quanta
`ifndef REG_FRAMER_DEFINES_VH
`define REG_FRAMER_DEFINES_VH
`define OPC_REGISTER 16'h0005
`define OPC_REG_ACK 16'h0006
`define FLG_REREG 8'h01
`define FLG_DEREG 8'h02
`define FLG_ACK 8'h03
`define FLG_NACK 8'h04
`define AFLG_NACK 8'h00
`define AFLG_ACK 8'h01
`define LLID_BCAST 16'h7fff
`define DA_GROUP_BIT 0
// byte positions within the frame payload
`define POS_OPC_HI 6'h00
`define POS_OPC_LO 6'h01
`define POS_PORT_HI 6'h02
`define POS_PORT_LO 6'h03
`define POS_FLAGS 6'h04
`define POS_SYNC_HI 6'h05
`define POS_SYNC_LO 6'h06
`define POS_PEND 6'h07
`define POS_ACK_SYNC_HI 6'h05
`define POS_ACK_SYNC_LO 6'h06
`define PAYLOAD_LEN 6'h28
// time figures
`define QUANTUM_NS 16
`define CLK_NS 5
`define QUANTUM_CYC 4
`define GRANT_LEAD_TQ 32'h0000_0400
`define GRANT_GAP_TQ 11'h400
`endif

// >>> dv/reg_framer_checker.sv
// assertion checker watching the registration framer ports
`timescale 1ns/10ps
module reg_framer_checker #(
   parameter GAP_TQ = 11'h400 // grant spacing, handed on by the bind
) (
   // clock and reset
   input wire clk_sys,
   input wire rstn,
   // registration request
   input wire regStart,
   input wire [47:0] regDestAddr,
   input wire regBusy,
   input wire regRefused_reg,
   // transmit stream
   input wire txValid_reg,
   input wire [7:0] txData_reg,
   input wire txLast_reg,
   input wire [15:0] txLlid_reg,
   input wire txReady,
   // grant gate and time base
   input wire grantReq,
   input wire [31:0] grantStart,
   input wire [31:0] localTime,
   input wire grantOk,
   input wire quantumTick_reg
);
   // lead in quanta, wraps to a huge value when start lies behind
   wire [31:0] lead = grantStart - localTime;
   wire take = regStart && !regBusy; // request seen while idle, framed or refused
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   a_group_refused: assert property (take && regDestAddr[0] |=> regRefused_reg && !regBusy)
      else $error("group destination not refused");
   a_opcode_first: assert property (
      take && !regDestAddr[0] |=> regBusy ##1 txValid_reg && txData_reg == 8'h00)
      else $error("frame does not open with opcode high octet");
   a_llid_bcast: assert property (txValid_reg |-> txLlid_reg == 16'h7fff)
      else $error("frame not tagged broadcast");
   a_octet_held: assert property (
      txValid_reg && !txReady |=> txValid_reg && $stable(txData_reg) && $stable(txLast_reg))
      else $error("octet dropped while stalled");
   a_frame_end: assert property (txValid_reg && txReady && txLast_reg |=> !txValid_reg)
      else $error("stream runs past last octet");
   a_tick_period: assert property (
      quantumTick_reg |=> !quantumTick_reg [*3] ##1 quantumTick_reg)
      else $error("quantum tick not every four cycles");
   a_grant_lead: assert property (
      grantOk |-> grantReq && !lead[31] && lead >= 32'h0000_0400)
      else $error("grant lead too short");
   a_grant_gap: assert property (grantOk |=> !grantOk [*8])
      else $error("grants too close");
   c_refused: cover property (regRefused_reg);
   c_frame: cover property (txValid_reg && txReady && txLast_reg);
   c_grant: cover property (grantOk);
endmodule
bind reg_framer reg_framer_checker #(.GAP_TQ(GAP_TQ)) u_reg_framer_checker (
   .clk_sys(clk_sys), .rstn(rstn), .regStart(regStart), .regDestAddr(regDestAddr),
   .regBusy(regBusy), .regRefused_reg(regRefused_reg), .txValid_reg(txValid_reg),
   .txData_reg(txData_reg), .txLast_reg(txLast_reg), .txLlid_reg(txLlid_reg),
   .txReady(txReady), .grantReq(grantReq), .grantStart(grantStart), .localTime(localTime),
   .grantOk(grantOk), .quantumTick_reg(quantumTick_reg));

// >>> dv/onu_model.sv
// far-side unit model: stalls the octet stream and sends ack frames
`timescale 1ns/10ps
module onu_model (
   // clock and stall control
   input wire clk_sys,
   input wire stall,
   // stream towards the unit and ack stream back
   output reg txReady,
   output reg rxValid,
   output reg [7:0] rxData,
   output reg rxLast
);
   initial begin
      txReady = 0;
      rxValid = 0;
      rxData = 8'h00;
      rxLast = 0;
   end
   // ready moves just after the edge, random while stalling
   always @(posedge clk_sys) begin
      #1;
      txReady = stall ? $urandom % 2 : 1'b1;
   end
   // ack from an active unit: opcode, port, flags, sync, then zero pad
   task send_ack(input [7:0] opLo, input [7:0] flg, input [15:0] port, input [15:0] sync,
      input integer len);
      integer i;
      reg [55:0] f;
      begin
         f = {8'h00, opLo, port, flg, sync};
         for (i = 0; i < len; i = i + 1) begin
            @(posedge clk_sys);
            #1;
            rxValid = 1;
            rxData = i < 7 ? f[55-8*i -: 8] : 8'h00;
            rxLast = i == len - 1;
         end
         @(posedge clk_sys);
         #1;
         rxValid = 0;
         rxLast = 0;
         rxData = ~rxData; // released line must not look like a valid octet
      end
   endtask
endmodule

// >>> dv/reg_framer_tb.sv
// self-checking bench for the registration framer
`timescale 1ns/10ps
module reg_framer_tb;
   reg clk_sys = 0, rstn = 0, regStart = 0, grantReq = 0, stall = 0;
   reg [47:0] regDestAddr = 0;
   reg [15:0] regPort = 0, syncA = 0, syncB = 0, syncC = 0;
   reg [7:0] regFlags = 0, regPendGrants = 0, outst = 0;
   reg [31:0] grantStart = 0;
   wire regBusy, regRefused_reg, txValid_reg, txLast_reg, txReady, rxValid, rxLast;
   wire ackSeen_reg, ackOk_reg, ackMatch_reg, deregPulse_reg, grantOk;
   wire [47:0] txDa;
   reg [31:0] lt = 32'h0000_0064;
   wire [7:0] txData_reg, rxData;
   wire [15:0] ackPort_reg, ackSync_reg, deregPort_reg;
   integer error_cnt = 0, checked = 0, deregs = 0, i, j, k, n;
   reg [7:0] expOct[$]; // expected octets in order
   reg [33:0] expAck[$]; // expected {match, ok, port, sync}
   reg [63:0] f;
   reg [17:0] s;
   always #2.5 clk_sys = ~clk_sys;
   reg_framer #(.GAP_TQ(11'h004)) u_reg_framer (.clk_sys(clk_sys), .rstn(rstn),
      .regStart(regStart), .regDestAddr(regDestAddr), .regPort(regPort), .regFlags(regFlags),
      .rxSyncPmd(syncA), .rxSyncPma(syncB), .rxSyncPcs(syncC), .regPendGrants(regPendGrants),
      .regBusy(regBusy), .regRefused_reg(regRefused_reg), .txValid_reg(txValid_reg),
      .txData_reg(txData_reg), .txLast_reg(txLast_reg), .txLlid_reg(), .txDestAddr_reg(txDa),
      .txReady(txReady), .rxValid(rxValid), .rxData(rxData), .rxLast(rxLast),
      .ackSeen_reg(ackSeen_reg), .ackOk_reg(ackOk_reg), .ackPort_reg(ackPort_reg),
      .ackSync_reg(ackSync_reg), .ackMatch_reg(ackMatch_reg), .deregPulse_reg(deregPulse_reg),
      .deregPort_reg(deregPort_reg), .grantReq(grantReq), .grantStart(grantStart),
      .localTime(lt), .grantsOutstanding(outst), .grantOk(grantOk),
      .quantumTick_reg());
   onu_model u_onu_model (.clk_sys(clk_sys), .stall(stall), .txReady(txReady),
      .rxValid(rxValid), .rxData(rxData), .rxLast(rxLast));
   task check(input [63:0] seen, input [63:0] exp, input [8*6:1] what);
      begin
         checked = checked + 1;
         if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("[ERR] %0s exp %h seen %h", what, exp, seen);
         end
      end
   endtask
   task end_of_test;
      begin
         $display("checks %0d mismatches %0d", checked, error_cnt);
         if (error_cnt == 0 && checked > 0) $display("RESULT: PASS");
         else $display("RESULT: FAIL");
         $finish;
      end
   endtask
   task step;
      begin
         @(posedge clk_sys);
         #1;
      end
   endtask
   // scoreboard: oldest note against each taken octet or parsed ack; a release against regPort
   always @(posedge clk_sys) begin
      if (rstn && txValid_reg && txReady)
         check(txData_reg, expOct.size() ? expOct.pop_front() : 64'hx, "octet");
      if (rstn && ackSeen_reg)
         check({ackMatch_reg, ackOk_reg, ackPort_reg, ackSync_reg},
            expAck.size() ? expAck.pop_front() : 64'hx, "ack");
      if (rstn && deregPulse_reg) begin
         deregs = deregs + 1;
         check(deregPort_reg, regPort, "dereg");
      end
   end
   // one request, retriggered while busy unless refused, which must be ignored
   task frame(input [47:0] da, input [7:0] flg);
      begin
         regDestAddr = da;
         regPort = $urandom;
         regFlags = flg;
         syncA = $urandom;
         syncB = $urandom;
         syncC = $urandom % 256;
         regPendGrants = 8'h02;
         s = syncA + syncB + syncC;
         if (s > 18'h0ffff) s = 18'h0ffff;
         f = {16'h0005, regPort, flg, s[15:0], 8'h02};
         for (i = 0; i < 40 && !da[0]; i = i + 1)
            expOct.push_back(i < 8 ? f[63-8*i -: 8] : 8'h00);
         regStart = 1;
         step;
         regStart = !da[0];
         if (da[0]) check(regRefused_reg, 1'b1, "refuse");
         step;
         regStart = 0;
         for (k = 0; k < 400 && regBusy !== 1'b0; k = k + 1) step;
         step;
         check(expOct.size(), 0, "count");
         if (!da[0]) check(txDa, da, "dest");
         $display("frame flags %h done", flg);
      end
   endtask
   // ack from the unit, only well-formed ones are reported
   task ack(input [7:0] opLo, input [7:0] flg, input integer len, input echo);
      begin
         n = echo ? {regPort, s[15:0]} : $urandom;
         if (opLo == 8'h06 && flg < 8'h02 && len >= 7)
            expAck.push_back({n == {regPort, s[15:0]}, flg[0], n});
         u_onu_model.send_ack(opLo, flg, n[31:16], n[15:0], len);
         repeat (2) step;
         check(expAck.size(), 0, "acks");
         $display("ack op %h flags %h done", opLo, flg);
      end
   endtask
   // grant query after an optional quiet gap
   task grant(input [31:0] lead, input [7:0] out, input exp, input integer gap);
      begin
         if (gap) begin
            grantReq = 0;
            repeat (gap) step;
         end
         lt = $urandom;
         grantStart = lt + lead;
         outst = out;
         grantReq = 1;
         #1;
         check(grantOk, exp, "grant");
         step;
      end
   endtask
   initial begin
      n = $urandom(55195);
      repeat (4) @(posedge clk_sys);
      #1;
      rstn = 1;
      frame(48'h0000_0000_0001, 8'h03);
      for (j = 1; j < 5; j = j + 1) begin
         stall = j[0];
         frame(48'h0000_0000_0002, j[7:0]);
      end
      check(deregs, 1, "deregs");
      for (j = 0; j < 6; j = j + 1)
         ack(j == 3 ? 8'h07 : 8'h06, j < 3 ? j[7:0] : 8'h01,
            j == 4 ? 6 : (j == 5 ? 7 : 40), j == 5);
      grant(32'h0000_03ff, 8'h00, 1'b0, 24);
      grant(32'hffff_fc00, 8'h00, 1'b0, 0);
      grant(32'h0000_0400, 8'h00, 1'b1, 0);
      grant(32'h0000_07d0, 8'h00, 1'b0, 0);
      grant(32'h0000_07d0, 8'h02, 1'b0, 24);
      grant(32'h0000_07d0, 8'h01, 1'b1, 0);
      grantReq = 0;
      $display("grant gate done");
      end_of_test;
   end
   initial begin
      #100000;
      error_cnt = error_cnt + 1;
      end_of_test;
   end
endmodule
